// [shared/sram_ctl_defines.svh]
`ifndef SRAM_CTL_DEFINES_SVH
`define SRAM_CTL_DEFINES_SVH

`define CLK_PERIOD_NS        100
// least times in ns, rounded up to whole cycles, never below one
`define WRITE_PULSE_NS       10
`define WRITE_SETUP_NS       0
`define WRITE_RECOVERY_NS    0
`define WRITE_TO_FLOAT_NS    7
`define READ_ACCESS_NS       15
`define CEIL_CYC(t)          ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                              (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CNT_W                4
`define STROBE_OFF           1'b1
`define STROBE_ON            1'b0

`endif

// [shared/sram_ctl_pkg.sv]
package sram_ctl_pkg;
	typedef struct packed {
		logic        write;
		logic [17:0] addr;
		logic [15:0] wdata;
		logic [1:0]  lanes;
	} req_s;

	typedef struct packed {
		logic chip_sel_n;
		logic write_en_n;
		logic out_en_n;
		logic upper_byte_sel_n;
		logic lower_byte_sel_n;
	} strobes_s;
endpackage

// [hdl/sram_ctl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sram_ctl_defines.svh"

// Operation
// - address changes only while write enable or chip select is high
// - never drive write data while memory drives the data pins
// - write window begins when last of the strobes goes low
// - write window ends when first of the strobes returns high
module sram_ctl #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 16
) (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  req_valid,
	input  wire sram_ctl_pkg::req_s    req,
	output var  logic                  req_ready,
	output var  logic                  rsp_valid,
	output var  logic [DATA_W-1:0]     rsp_rdata,
	output var  logic [ADDR_W-1:0]     sram_addr,
	output var  sram_ctl_pkg::strobes_s strobes,
	input  wire logic [DATA_W-1:0]     data_pins_in,
	output var  logic [DATA_W-1:0]     data_pins_out,
	output var  logic [DATA_W-1:0]     data_pins_oe
);
	localparam logic [`CNT_W-1:0] PULSE_CYC = `CNT_W'(`CEIL_CYC(`WRITE_PULSE_NS));
	localparam logic [`CNT_W-1:0] SETUP_CYC = `CNT_W'(`CEIL_CYC(`WRITE_SETUP_NS));
	localparam logic [`CNT_W-1:0] RECOV_CYC = `CNT_W'(`CEIL_CYC(`WRITE_RECOVERY_NS));
	localparam logic [`CNT_W-1:0] FLOAT_CYC = `CNT_W'(`CEIL_CYC(`WRITE_TO_FLOAT_NS));
	localparam logic [`CNT_W-1:0] READ_CYC  = `CNT_W'(`CEIL_CYC(`READ_ACCESS_NS));

	typedef enum logic [2:0] {IDLE, W_SETUP, W_PULSE, W_RECOV, R_ACCESS, R_DONE} state_e;

	state_e                 state, next_state;
	logic [`CNT_W-1:0]      cnt, next_cnt;
	logic                   write_q, next_write_q;
	logic [1:0]             lanes_q, next_lanes_q;
	logic [DATA_W-1:0]      sync1, sync2;
	logic [DATA_W-1:0]      wdata_q, next_wdata_q;
	logic                   next_req_ready, next_rsp_valid;
	logic [DATA_W-1:0]      next_rsp_rdata, next_data_out, next_data_oe;
	logic [ADDR_W-1:0]      next_addr;
	sram_ctl_pkg::strobes_s next_strobes;

	function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes);
		lane_mask = {{(DATA_W/2){lanes[1]}}, {(DATA_W/2){lanes[0]}}};
	endfunction

	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_write_q   = write_q;
		next_lanes_q   = lanes_q;
		next_req_ready = 1'b0;
		next_rsp_valid = 1'b0;
		next_rsp_rdata = rsp_rdata;
		next_addr      = sram_addr;
		next_data_out  = data_pins_out;
		next_data_oe   = data_pins_oe;
		next_strobes   = strobes;
		case (state)
			IDLE: begin
				next_strobes = '{`STROBE_OFF, `STROBE_OFF, `STROBE_OFF, `STROBE_OFF, `STROBE_OFF};
				next_data_oe = '0;
				if (req_valid && req_ready) begin
					// address moves only with write enable high; a read lowers chip select with it
					next_addr    = req.addr[ADDR_W-1:0];
					next_write_q = req.write;
					next_lanes_q = req.lanes;
					next_cnt     = SETUP_CYC;
					if (req.write) begin
						next_state = W_SETUP;
					end else begin
						next_state = R_ACCESS;
						// one more cycle covers the two-stage pin synchroniser
						next_cnt   = READ_CYC + `CNT_W'(1);
						// read: output enable with chip and byte selects
						next_strobes.chip_sel_n       = `STROBE_ON;
						next_strobes.out_en_n         = `STROBE_ON;
						next_strobes.upper_byte_sel_n = ~req.lanes[1];
						next_strobes.lower_byte_sel_n = ~req.lanes[0];
					end
				end else begin
					next_req_ready = 1'b1;
				end
			end
			W_SETUP: begin
				// output enable stays high so the memory floats; drive only then
				next_data_out = wdata_q;
				next_data_oe  = lane_mask(lanes_q);
				if (cnt <= `CNT_W'(1)) begin
					// write window opens: chip select, write enable and the selected byte selects fall together
					next_strobes.chip_sel_n       = `STROBE_ON;
					next_strobes.write_en_n       = `STROBE_ON;
					next_strobes.upper_byte_sel_n = ~lanes_q[1];
					next_strobes.lower_byte_sel_n = ~lanes_q[0];
					next_cnt   = PULSE_CYC;
					next_state = W_PULSE;
				end else begin
					next_cnt = cnt - `CNT_W'(1);
				end
			end
			W_PULSE: begin
				if (cnt <= `CNT_W'(1)) begin
					// write window closes: write enable rises first, data held
					next_strobes.write_en_n = `STROBE_OFF;
					next_cnt   = RECOV_CYC;
					next_state = W_RECOV;
				end else begin
					next_cnt = cnt - `CNT_W'(1);
				end
			end
			W_RECOV: begin
				next_strobes = '{`STROBE_OFF, `STROBE_OFF, `STROBE_OFF, `STROBE_OFF, `STROBE_OFF};
				if (cnt <= `CNT_W'(1)) begin
					next_data_oe   = '0;
					next_rsp_valid = 1'b1;
					next_state     = IDLE;
				end else begin
					next_cnt = cnt - `CNT_W'(1);
				end
			end
			R_ACCESS: begin
				if (cnt <= `CNT_W'(1)) begin
					next_state = R_DONE;
				end else begin
					next_cnt = cnt - `CNT_W'(1);
				end
			end
			R_DONE: begin
				// two-stage synchronised pins; unselected lanes read as zero
				next_rsp_rdata = sync2 & lane_mask(lanes_q);
				next_rsp_valid = 1'b1;
				next_strobes   = '{`STROBE_OFF, `STROBE_OFF, `STROBE_OFF, `STROBE_OFF, `STROBE_OFF};
				next_cnt       = FLOAT_CYC;
				next_state     = IDLE;
			end
			default: begin
				next_state = IDLE;
			end
		endcase
	end

	// write data is captured at acceptance so it stands through the window
	always_comb begin
		next_wdata_q = wdata_q;
		if (state == IDLE && req_valid && req_ready && req.write) begin
			next_wdata_q = req.wdata[DATA_W-1:0] & lane_mask(req.lanes);
		end
	end

	always_ff @(posedge ref_clk) begin
		sync1 <= data_pins_in;
		sync2 <= sync1;
		if (sys_rst) begin
			state         <= IDLE;
			cnt           <= '0;
			write_q       <= 1'b0;
			lanes_q       <= '0;
			req_ready     <= 1'b0;
			rsp_valid     <= 1'b0;
			rsp_rdata     <= '0;
			sram_addr     <= '0;
			wdata_q       <= '0;
			data_pins_out <= '0;
			data_pins_oe  <= '0;
			strobes       <= '{`STROBE_OFF, `STROBE_OFF, `STROBE_OFF, `STROBE_OFF, `STROBE_OFF};
		end else begin
			state         <= next_state;
			cnt           <= next_cnt;
			write_q       <= next_write_q;
			lanes_q       <= next_lanes_q;
			req_ready     <= next_req_ready;
			rsp_valid     <= next_rsp_valid;
			rsp_rdata     <= next_rsp_rdata;
			sram_addr     <= next_addr;
			wdata_q       <= next_wdata_q;
			data_pins_out <= next_data_out;
			data_pins_oe  <= next_data_oe;
			strobes       <= next_strobes;
		end
	end

	logic write_on;
	assign write_on = !strobes.chip_sel_n && !strobes.write_en_n
		&& (!strobes.upper_byte_sel_n || !strobes.lower_byte_sel_n);

	sequence win_open_s;
		!write_on ##1 write_on;
	endsequence

	addr_stable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$changed(sram_addr) |-> strobes.write_en_n || strobes.chip_sel_n)
		else $error("address moved with strobes low");
	no_contend_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!strobes.out_en_n |-> data_pins_oe == '0)
		else $error("host drives while memory may drive");
	float_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!strobes.write_en_n |-> strobes.out_en_n)
		else $error("output enable low during write");
	window_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		win_open_s |-> write_on [*1] ##1 !write_on)
		else $error("write window length wrong");
	window_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$fell(write_on) |-> strobes.write_en_n && !strobes.chip_sel_n && data_pins_oe != '0)
		else $error("write window did not end on write enable with data held");
	lane_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		write_on |-> data_pins_oe == lane_mask({~strobes.upper_byte_sel_n,
			~strobes.lower_byte_sel_n}))
		else $error("byte lanes mismatch");
	write_has_lane_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == W_PULSE && lanes_q != 2'b00) |-> write_on)
		else $error("write pulse without full strobe set");
	read_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == R_ACCESS) |-> !strobes.out_en_n && !strobes.chip_sel_n && data_pins_oe == '0)
		else $error("read strobes wrong");
endmodule // sram_ctl

`default_nettype wire

// [verification/sram_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sram_model (
	input  wire logic [17:0]          addr,
	input  wire sram_ctl_pkg::strobes_s st,
	input  wire logic [15:0]          pins,
	output var  logic [15:0]          q,
	output var  logic [15:0]          q_oe
);
	logic [15:0] mem [int];
	logic [15:0] d_l;
	logic [15:0] last = 16'h0;
	logic [17:0] a_l;
	logic [1:0]  ln_l;
	logic        wnd;
	logic        rd;
	assign wnd = !st.chip_sel_n && !st.write_en_n && !(st.upper_byte_sel_n && st.lower_byte_sel_n);
	assign rd = !st.chip_sel_n && !st.out_en_n && st.write_en_n;
	always @* if (wnd) begin
		a_l = addr;
		d_l = pins;
		ln_l = ~{st.upper_byte_sel_n, st.lower_byte_sel_n};
	end
	// data lands when the first strobe of the window rises
	always @(negedge wnd) begin
		logic [15:0] o;
		o = mem.exists(a_l) ? mem[a_l] : 16'h0;
		mem[a_l] = {ln_l[1] ? d_l[15:8] : o[15:8], ln_l[0] ? d_l[7:0] : o[7:0]};
	end
	always @(addr or st or rd) begin
		q_oe = rd ? {{8{!st.upper_byte_sel_n}}, {8{!st.lower_byte_sel_n}}} : 16'h0;
		if (rd) last = mem.exists(addr) ? mem[addr] : 16'h0;
		q = (q_oe & last) | (~q_oe & ~last);
	end
endmodule // sram_model
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
	sram_ctl_pkg::req_s req = '0;
	logic req_ready, rsp_valid;
	logic [15:0] rsp_rdata, pins, pout, poe, q, q_oe;
	logic [17:0] sram_addr, pa;
	sram_ctl_pkg::strobes_s strobes, ps;
	logic [15:0] exp_mem [int];
	logic [16:0] exp_q [$];
	int bad_count = 0, num_checks = 0, cyc = 0;
	initial forever #50 ref_clk = ~ref_clk;
	assign pins = (poe & pout) | (~poe & q);
	sram_ctl uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.sram_addr(sram_addr), .strobes(strobes), .data_pins_in(pins),
		.data_pins_out(pout), .data_pins_oe(poe));
	sram_model mdl (.addr(sram_addr), .st(strobes), .pins(pins), .q(q), .q_oe(q_oe));
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
		num_checks++;
		if (seen !== ex) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	function automatic logic [17:0] pick(input int k);
		return (k == 3) ? 18'h3ffff : 18'(k);
	endfunction
	task automatic issue(input logic w, input logic [17:0] a, input logic [15:0] d,
		input logic [1:0] ln);
		int n;
		logic [15:0] o, m;
		n = 0;
		req_valid = 1'b1;
		req = '{w, a, d, ln};
		// ready is registered, so it is looked at on the falling edge where it stands
		while (req_ready !== 1'b1 && n < 50) begin
			n++;
			@(negedge ref_clk);
		end
		@(posedge ref_clk);
		@(negedge ref_clk);
		m = {{8{ln[1]}}, {8{ln[0]}}};
		o = exp_mem.exists(a) ? exp_mem[a] : 16'h0;
		if (w) exp_mem[a] = (d & m) | (o & ~m);
		exp_q.push_back({!w, o & m});
	endtask
	always @(negedge ref_clk) begin
		logic [16:0] e;
		if (!sys_rst) begin
			check("contention", q_oe & poe, 16'h0);
			if (sram_addr !== pa)
				check("addr change", 16'((ps.chip_sel_n | ps.write_en_n) & (strobes.chip_sel_n | strobes.write_en_n)), 16'h1);
			if (rsp_valid === 1'b1) begin
				if (exp_q.size() == 0) check("spare response", 16'h1, 16'h0);
				else begin
					e = exp_q.pop_front();
					if (e[16]) check("read data", rsp_rdata, e[15:0]);
				end
			end
		end
		pa = sram_addr;
		ps = strobes;
	end
	always @(posedge ref_clk) if (++cyc > 5000) begin
		bad_count++;
		close_out;
	end
	initial begin
		void'($urandom(32'hbc2f4e18));
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk);
		sys_rst = 1'b0;
		for (int i = 0; i < 4; i++) issue(1'b1, pick(i), 16'($urandom), 2'b11);
		for (int i = 0; i < 80; i++)
			issue(1'($urandom), pick($urandom % 4), 16'($urandom), 2'($urandom));
		for (int i = 0; i < 4; i++) issue(1'b0, pick(i), 16'h0, 2'b11);
		req_valid = 1'b0;
		for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(negedge ref_clk);
		check("pending responses", 16'(exp_q.size()), 16'h0);
		close_out;
	end
endmodule // tb_top
`default_nettype wire
